// ==== isf_pkg.sv ====
// Package with register offsets, bit positions and reset values for the status block.
package isf_pkg;
  localparam logic [3:0]  STAT_ADDR     = 4'h0;
  localparam logic [3:0]  CTRL_ADDR     = 4'h4;
  localparam int          ACK_BIT       = 15;
  localparam int          TXP_BIT       = 14;
  localparam int          BCL_BIT       = 10;
  localparam int          GC_BIT        = 9;
  localparam int          TEN_BIT       = 8;
  localparam int          WCOL_BIT      = 7;
  localparam int          OVF_BIT       = 6;
  localparam int          DA_BIT        = 5;
  localparam int          STOP_BIT      = 4;
  localparam int          START_BIT     = 3;
  localparam int          RW_BIT        = 2;
  localparam int          RXF_BIT       = 1;
  localparam int          TXF_BIT       = 0;
  localparam int          CTRL_ON_BIT   = 0;
  localparam logic [31:0] STAT_RESET    = 32'h0000_0000;
  localparam logic [31:0] STAT_IMPL     = 32'h0000_C7FF;
endpackage

// ==== isf_status.sv ====
// Status-flag logic of a two-wire bus controller with a plain register port.
// Summary of operation
// - As master transmitter the ack flag is updated at the end of the ack slot: 1 for no ack, 0 for ack.
// - The transmit-in-progress flag rises when a master send starts and clears at the end of the slave ack.
// - The bus-collision flag sets on a collision and clears only when the module is turned off and on again.
// - The general-call flag sets on a general call address match and clears at a stop condition.
// - The ten-bit flag sets when the second ten-bit address byte matches and clears at a stop condition.
// - A transmit buffer write while busy fails and sets the write-collision flag, cleared only by software.
// - Moving a received byte into a still-full receive buffer sets the overflow flag, cleared by software.
// - In slave mode an own address match clears the data-or-address flag and a data byte sets it.
// - The upper sixteen bits and bits thirteen to eleven of the status register read as zero.
//
// The strobed register port and the register addresses are this design's own decisions.
module isf_status
  import isf_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        ack_slot_end_i,
  input  wire logic        ack_nack_i,
  input  wire logic        master_tx_start_i,
  input  wire logic        collision_i,
  input  wire logic        gen_call_match_i,
  input  wire logic        ten_bit_match_i,
  input  wire logic        stop_det_i,
  input  wire logic        start_det_i,
  input  wire logic        own_addr_match_i,
  input  wire logic        slave_data_rx_i,
  input  wire logic        rx_move_i,
  input  wire logic        rx_dir_read_i,
  input  wire logic        busy_i,
  input  wire logic        tx_wr_i,
  input  wire logic        rx_read_i,
  input  wire logic        tx_done_i,
  output logic             on_o,
  output logic             tx_accept_o
);
  logic        ack_q, txp_q, bcl_q, gc_q, ten_q, wcol_q, ovf_q, da_q;
  logic        stop_q, start_q, rw_q, rxf_q, txf_q, on_q;
  logic [31:0] rdata_q;
  logic [31:0] stat_w;
  logic        wr_stat_w, wr_ctrl_w, on_rise_w, wcol_ev_w, ovf_ev_w;

  assign wr_stat_w = wr_i && (addr_i == STAT_ADDR);
  assign wr_ctrl_w = wr_i && (addr_i == CTRL_ADDR);
  assign on_rise_w = wr_ctrl_w && wdata_i[CTRL_ON_BIT] && !on_q;
  assign wcol_ev_w = tx_wr_i && (busy_i || txf_q);
  assign ovf_ev_w  = rx_move_i && rxf_q && !rx_read_i;
  assign tx_accept_o = tx_wr_i && !wcol_ev_w;
  assign on_o = on_q;

  always_comb begin
    stat_w = STAT_RESET;
    stat_w[ACK_BIT]   = ack_q;
    stat_w[TXP_BIT]   = txp_q;
    stat_w[BCL_BIT]   = bcl_q;
    stat_w[GC_BIT]    = gc_q;
    stat_w[TEN_BIT]   = ten_q;
    stat_w[WCOL_BIT]  = wcol_q;
    stat_w[OVF_BIT]   = ovf_q;
    stat_w[DA_BIT]    = da_q;
    stat_w[STOP_BIT]  = stop_q;
    stat_w[START_BIT] = start_q;
    stat_w[RW_BIT]    = rw_q;
    stat_w[RXF_BIT]   = rxf_q;
    stat_w[TXF_BIT]   = txf_q;
    stat_w = stat_w & STAT_IMPL;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      txp_q <= 1'b0;
      bcl_q <= 1'b0;
      gc_q <= 1'b0;
      ten_q <= 1'b0;
      wcol_q <= 1'b0;
      ovf_q <= 1'b0;
      da_q <= 1'b0;
      stop_q <= 1'b0;
      start_q <= 1'b0;
      rw_q <= 1'b0;
      rxf_q <= 1'b0;
      txf_q <= 1'b0;
      on_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= 32'h0000_0000;
      if (rd_i && addr_i == STAT_ADDR) begin
        rdata_q <= stat_w;
      end else if (rd_i && addr_i == CTRL_ADDR) begin
        rdata_q <= {31'h0000_0000, on_q};
      end
      if (wr_ctrl_w) begin
        on_q <= wdata_i[CTRL_ON_BIT];
      end
      if (ack_slot_end_i && txp_q) begin
        ack_q <= ack_nack_i;
      end
      if (master_tx_start_i) begin
        txp_q <= 1'b1;
      end else if (ack_slot_end_i) begin
        txp_q <= 1'b0;
      end
      // Collision is only released by an off-to-on transition of the module.
      if (collision_i) begin
        bcl_q <= 1'b1;
      end else if (on_rise_w) begin
        bcl_q <= 1'b0;
      end
      if (gen_call_match_i) begin
        gc_q <= 1'b1;
      end else if (stop_det_i) begin
        gc_q <= 1'b0;
      end
      if (ten_bit_match_i) begin
        ten_q <= 1'b1;
      end else if (stop_det_i) begin
        ten_q <= 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle.
      if (wcol_ev_w) begin
        wcol_q <= 1'b1;
      end else if (wr_stat_w && !wdata_i[WCOL_BIT]) begin
        wcol_q <= 1'b0;
      end
      if (ovf_ev_w) begin
        ovf_q <= 1'b1;
      end else if (wr_stat_w && !wdata_i[OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
      if (slave_data_rx_i) begin
        da_q <= 1'b1;
      end else if (own_addr_match_i) begin
        da_q <= 1'b0;
      end
      if (stop_det_i) begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
      end else if (start_det_i) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
      end
      if (own_addr_match_i) begin
        rw_q <= rx_dir_read_i;
      end
      if (rx_move_i && !rxf_q) begin
        rxf_q <= 1'b1;
      end else if (rx_read_i) begin
        rxf_q <= rx_move_i;
      end
      if (tx_accept_o) begin
        txf_q <= 1'b1;
      end else if (tx_done_i) begin
        txf_q <= 1'b0;
      end
    end
  end

  assign rdata_o = rdata_q;

  property p_ack_update;
    @(posedge mclk_i) disable iff (rst_i)
      (ack_slot_end_i && txp_q) |=> (ack_q == $past(ack_nack_i));
  endproperty
  a_ack_update: assert property (p_ack_update) else $error("ack flag wrong");

  property p_txp_clear;
    @(posedge mclk_i) disable iff (rst_i)
      (ack_slot_end_i && !master_tx_start_i) |=> !txp_q;
  endproperty
  a_txp_clear: assert property (p_txp_clear) else $error("txp not cleared");

  property p_txp_set;
    @(posedge mclk_i) disable iff (rst_i) master_tx_start_i |=> txp_q;
  endproperty
  a_txp_set: assert property (p_txp_set) else $error("txp not set");

  property p_bcl_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (bcl_q && !on_rise_w) |=> bcl_q;
  endproperty
  a_bcl_hold: assert property (p_bcl_hold) else $error("bcl dropped");

  property p_bcl_set;
    @(posedge mclk_i) disable iff (rst_i) collision_i |=> bcl_q;
  endproperty
  a_bcl_set: assert property (p_bcl_set) else $error("bcl not set");

  property p_gc_stop;
    @(posedge mclk_i) disable iff (rst_i)
      (stop_det_i && !gen_call_match_i) |=> !gc_q;
  endproperty
  a_gc_stop: assert property (p_gc_stop) else $error("gc not cleared");

  property p_ten_set;
    @(posedge mclk_i) disable iff (rst_i) ten_bit_match_i |=> ten_q;
  endproperty
  a_ten_set: assert property (p_ten_set) else $error("ten not set");

  property p_ten_stop;
    @(posedge mclk_i) disable iff (rst_i)
      (stop_det_i && !ten_bit_match_i) |=> !ten_q;
  endproperty
  a_ten_stop: assert property (p_ten_stop) else $error("ten kept");

  // A refused write is not taken and leaves the collision flag behind.
  sequence s_tx_refused;
    !tx_accept_o ##1 wcol_q;
  endsequence

  property p_wcol;
    @(posedge mclk_i) disable iff (rst_i)
      (tx_wr_i && busy_i) |-> s_tx_refused;
  endproperty
  a_wcol: assert property (p_wcol) else $error("wcol missed");

  property p_ovf;
    @(posedge mclk_i) disable iff (rst_i) ovf_ev_w |=> ovf_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("ovf missed");

  property p_da;
    @(posedge mclk_i) disable iff (rst_i)
      (own_addr_match_i && !slave_data_rx_i) |=> !da_q;
  endproperty
  a_da: assert property (p_da) else $error("da not cleared");

  property p_zero;
    @(posedge mclk_i) disable iff (rst_i)
      $past(rd_i) |-> (rdata_o[31:16] == 16'h0000) &&
        (($past(addr_i) != STAT_ADDR) || (rdata_o[13:11] == 3'h0));
  endproperty
  a_zero: assert property (p_zero) else $error("reserved bits set");

  property p_rw_latch;
    @(posedge mclk_i) disable iff (rst_i)
      own_addr_match_i |=> (rw_q == $past(rx_dir_read_i));
  endproperty
  a_rw_latch: assert property (p_rw_latch) else $error("rw wrong");

  property p_rst_clr;
    @(posedge mclk_i)
      rst_i |=> (stat_w == STAT_RESET) && !on_q &&
        (rdata_o == 32'h0000_0000);
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("not reset");
endmodule

// ==== isf_bus_model.sv ====
// Bus-side model: other masters and slaves raising bus events.
module isf_bus_model (
  input  wire logic       mclk_i,
  output logic      [9:0] ev_o,
  output logic            lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ev_o = 10'h000;
    lvl_o = 1'b0;
  end
  // One-cycle event with its level (no-ack or read direction) beside it.
  task automatic pulse(input int i, input logic l);
    @(posedge mclk_i);
    ev_o[i] <= 1'b1;
    lvl_o <= l;
    @(posedge mclk_i);
    ev_o <= 10'h000;
  endtask
endmodule

// ==== isf_status_bench.sv ====
// Self-checking bench for the status-flag block.
module isf_status_bench;
  import isf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        busy_i = 1'b0, tx_wr_i = 1'b0, rx_read_i = 1'b0;
  logic        tx_done_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic        on_o, tx_accept_o, lvl;
  logic [9:0]  ev;
  int          error_cnt = 0, num_checks = 0;
  isf_bus_model bm (.mclk_i, .ev_o(ev), .lvl_o(lvl));
  isf_status dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .ack_slot_end_i(ev[0]), .ack_nack_i(lvl), .master_tx_start_i(ev[1]),
    .collision_i(ev[2]), .gen_call_match_i(ev[3]), .ten_bit_match_i(ev[4]),
    .stop_det_i(ev[5]), .start_det_i(ev[6]), .own_addr_match_i(ev[7]),
    .slave_data_rx_i(ev[8]), .rx_move_i(ev[9]), .rx_dir_read_i(lvl),
    .busy_i, .tx_wr_i, .rx_read_i, .tx_done_i, .on_o, .tx_accept_o);
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic fail(input string s);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    v = rdata_o;
  endtask
  // Reads the status word and compares the masked flags.
  task automatic chk(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(STAT_ADDR, v);
    num_checks += 2;
    if ((v & m) !== e) fail("status flags");
    if ((v & ~STAT_IMPL) !== 32'h0) fail("reserved bits set");
  endtask
  task automatic t_reset();
    logic [31:0] v;
    chk(32'hFFFF_FFFF, STAT_RESET);
    rd(4'h8, v);
    num_checks++;
    if (v !== 32'h0) fail("unmapped read");
  endtask
  task automatic t_tx();
    bm.pulse(1, 1'b0);
    chk(32'hC000, 32'h4000);
    bm.pulse(0, 1'b1);
    chk(32'hC000, 32'h8000);
    bm.pulse(1, 1'b0);
    bm.pulse(0, 1'b0);
    chk(32'hC000, 32'h0000);
  endtask
  task automatic t_bcl();
    logic [31:0] v;
    wr(CTRL_ADDR, 32'h1);
    bm.pulse(2, 1'b0);
    wr(STAT_ADDR, 32'h0);
    chk(32'h0400, 32'h0400);
    wr(CTRL_ADDR, 32'h0);
    wr(CTRL_ADDR, 32'h1);
    chk(32'h0400, 32'h0000);
    num_checks++;
    if (on_o !== 1'b1) fail("module not on");
    rd(CTRL_ADDR, v);
    num_checks++;
    if (v !== 32'h0000_0001) fail("control readback");
  endtask
  task automatic t_gc();
    bm.pulse(3, 1'b0);
    bm.pulse(4, 1'b0);
    chk(32'h0300, 32'h0300);
    bm.pulse(5, 1'b0);
    chk(32'h0310, 32'h0010);
    bm.pulse(6, 1'b0);
    chk(32'h0018, 32'h0008);
  endtask
  task automatic t_wcol();
    @(posedge mclk_i);
    busy_i <= 1'b1;
    tx_wr_i <= 1'b1;
    @(negedge mclk_i);
    num_checks++;
    if (tx_accept_o !== 1'b0) fail("write accepted while busy");
    @(posedge mclk_i);
    tx_wr_i <= 1'b0;
    busy_i <= 1'b0;
    chk(32'h0081, 32'h0080);
    wr(STAT_ADDR, 32'h0);
    chk(32'h0080, 32'h0000);
    @(posedge mclk_i);
    tx_wr_i <= 1'b1;
    @(negedge mclk_i);
    num_checks++;
    if (tx_accept_o !== 1'b1) fail("idle write refused");
    @(posedge mclk_i);
    tx_wr_i <= 1'b0;
    chk(32'h0081, 32'h0001);
    @(posedge mclk_i);
    tx_wr_i <= 1'b1;
    @(negedge mclk_i);
    num_checks++;
    if (tx_accept_o !== 1'b0) fail("write accepted while full");
    @(posedge mclk_i);
    tx_wr_i <= 1'b0;
    tx_done_i <= 1'b1;
    @(posedge mclk_i);
    tx_done_i <= 1'b0;
    chk(32'h0081, 32'h0080);
    wr(STAT_ADDR, 32'h0);
    chk(32'h0081, 32'h0000);
  endtask
  // Reset in mid-run with flags and the enable set must clear them all.
  task automatic t_rst();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    chk(32'hFFFF_FFFF, STAT_RESET);
    num_checks++;
    if (on_o !== 1'b0) fail("module still on after reset");
  endtask
  task automatic t_ovf();
    bm.pulse(9, 1'b0);
    chk(32'h0042, 32'h0002);
    bm.pulse(9, 1'b0);
    chk(32'h0040, 32'h0040);
    @(posedge mclk_i);
    rx_read_i <= 1'b1;
    @(posedge mclk_i);
    rx_read_i <= 1'b0;
    wr(STAT_ADDR, 32'h0);
    chk(32'h0042, 32'h0000);
  endtask
  task automatic t_da();
    bm.pulse(8, 1'b0);
    chk(32'h0020, 32'h0020);
    bm.pulse(7, 1'b1);
    chk(32'h0024, 32'h0004);
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx();
    t_bcl();
    t_gc();
    t_wcol();
    t_ovf();
    t_da();
    t_rst();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    fail("run too long");
    end_of_test();
  end
endmodule
